// *** tlnmi_top.sv ***
// Top-level (non-maskable) interrupt, peripheral channel gating, motor trip and wake unit.
// Assumes pins are asynchronous; cpu handshakes and software strobes are on clk.
`timescale 1ns/10ps
module tlnmi_top #(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic nmi_pin,
	input wire logic [tlnmi_pkg::WAKE_PINS-1:1] wake_pins,
	input wire logic watchdog_eoc,
	input wire logic top_source_select_wr,
	input wire logic top_source_select_in,
	input wire logic top_edge_select_wr,
	input wire logic top_edge_select_in,
	input wire logic top_mask_wr,
	input wire logic top_mask_in,
	input wire logic top_pending_set,
	input wire logic top_lock_set,
	input wire logic global_irq_enable_in,
	input wire logic [CHANNELS-1:0] chan_event,
	input wire logic [CHANNELS-1:0] chan_pending_set,
	input wire logic [CHANNELS-1:0] chan_pending_clr,
	input wire logic [CHANNELS-1:0] chan_mask_wr,
	input wire logic [CHANNELS-1:0] chan_mask_in,
	input wire logic [3*CHANNELS-1:0] chan_prio_in,
	input wire logic [CHANNELS-1:0] chan_prio_wr,
	input wire logic [2:0] current_priority_level,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_pending_set,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_pending_clr,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_mask_wr,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_mask_in,
	input wire logic motor_flag_clr,
	input wire logic stop_mode,
	input wire logic write_done,
	input wire logic instr_end,
	input wire tlnmi_pkg::tlnmi_entry_cfg_t entry_cfg,
	input wire logic top_return,
	input wire logic per_return,
	output logic top_source_select,
	output logic top_edge_select,
	output logic top_pending_flag,
	output logic top_mask_enable,
	output logic top_unmaskable_lock,
	output logic [CHANNELS-1:0] pending_flag,
	output logic [CHANNELS-1:0] mask_flag,
	output logic [3*CHANNELS-1:0] priority_field,
	output logic [tlnmi_pkg::WAKE_LINES-1:0] wake_pending,
	output logic [tlnmi_pkg::WAKE_LINES-1:0] wake_mask,
	output logic wake_irq,
	output logic wake_request,
	output logic motor_nmi_flag,
	output logic motor_phases_hiz,
	output logic abort_instr,
	output logic entry_start,
	output logic isr_start,
	output logic isr_top,
	output logic [2:0] isr_chan,
	output logic in_top_service
);
	// ==========================================================
	// Input synchronisers
	logic [1:0] nmi_sync;
	logic [tlnmi_pkg::WAKE_PINS-1:1] wk_s1, wk_s2;
	logic nmi_prev, wdg_prev;
	logic next_nmi_prev, next_wdg_prev;
	// Two flip-flops for the asynchronous pins
	always_ff @(posedge clk) begin
		if (reset) begin
			nmi_sync <= 2'h0;
			wk_s1 <= '0;
			wk_s2 <= '0;
		end else begin
			nmi_sync <= {nmi_sync[0], nmi_pin};
			wk_s1 <= wake_pins;
			wk_s2 <= wk_s1;
		end
	end
	wire logic nmi_level = nmi_sync[1];
	// ==========================================================
	// Top trigger detection
	logic top_event;
	logic motor_event;
	always_comb begin
		next_nmi_prev = nmi_level;
		next_wdg_prev = watchdog_eoc;
		// Rising or falling on the synchronised pin
		motor_event = top_edge_select ? (nmi_level & ~nmi_prev) : (~nmi_level & nmi_prev);
		// Pin path, or watchdog rising end of count
		top_event = top_source_select ? motor_event : (watchdog_eoc & ~wdg_prev);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			nmi_prev <= 1'b0;
			wdg_prev <= 1'b0;
		end else begin
			nmi_prev <= next_nmi_prev;
			wdg_prev <= next_wdg_prev;
		end
	end
	// ==========================================================
	// Arbitration divider and sequencer state
	tlnmi_pkg::tlnmi_state_t state, next_state;
	logic [2:0] arb_cnt, next_arb_cnt;
	logic [4:0] entry_cnt, next_entry_cnt;
	tlnmi_pkg::tlnmi_grant_t grant, next_grant, win;
	logic sample;
	logic top_ack, per_ack;
	logic top_req, per_any;
	logic [2:0] best_prio;
	logic [2:0] best_chan;
	logic [4:0] entry_len;
	// Priority search over channels, lowest value wins, seven excluded
	always_comb begin
		best_prio = tlnmi_pkg::PRIO_NEVER;
		best_chan = 3'h0;
		per_any = 1'b0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (pending_flag[i] & mask_flag[i] & global_irq_enable_in
				& (priority_field[3*i +: 3] != tlnmi_pkg::PRIO_NEVER)
				& (priority_field[3*i +: 3] <= best_prio)
				& (priority_field[3*i +: 3] < current_priority_level)) begin
				best_prio = priority_field[3*i +: 3];
				best_chan = 3'(i);
				per_any = 1'b1;
			end
		end
		// Lock bypasses global enable; else mask plus enable plus pending
		top_req = top_pending_flag & (top_unmaskable_lock
			| (top_mask_enable & global_irq_enable_in));
	end
	// Sequencer: sample, wait for abortable point, ack, entry cycles, service
	always_comb begin
		next_state = state;
		next_grant = grant;
		next_entry_cnt = entry_cnt;
		next_arb_cnt = (arb_cnt == tlnmi_pkg::ARB_LAST) ? 3'h0 : arb_cnt + 3'h1;
		sample = (arb_cnt == tlnmi_pkg::ARB_LAST);
		top_ack = 1'b0;
		per_ack = 1'b0;
		win = '0;
		// Top beats every channel
		if (top_req & ~stop_mode) begin
			win = '{valid: 1'b1, top: 1'b1, chan: 3'h0};
		end else if (per_any & ~stop_mode) begin
			win = '{valid: 1'b1, top: 1'b0, chan: best_chan};
		end
		entry_len = 5'(tlnmi_pkg::ENTRY_BASE_CYCLES)
			+ (entry_cfg.stack_in_regfile ? 5'(tlnmi_pkg::ENTRY_STACK_CYCLES) : 5'h0)
			+ (entry_cfg.code_segment_push_enable ? 5'(tlnmi_pkg::ENTRY_CSR_CYCLES) : 5'h0)
			+ (entry_cfg.wait_for_irq ? 5'(tlnmi_pkg::ENTRY_WFI_CYCLES) : 5'h0);
		case (state)
			tlnmi_pkg::TLNMI_IDLE: begin
				if (sample & win.valid) begin
					next_grant = win;
					next_state = tlnmi_pkg::TLNMI_WAIT;
				end
			end
			tlnmi_pkg::TLNMI_WAIT: begin
				// Abort at once if nothing written, else at instruction end
				if (~write_done | instr_end) begin
					next_state = tlnmi_pkg::TLNMI_ACK;
				end
			end
			tlnmi_pkg::TLNMI_ACK: begin
				// One extra clock for acknowledge; clears the winning pending flag
				top_ack = grant.top;
				per_ack = ~grant.top;
				next_entry_cnt = entry_len - 5'h1;
				next_state = tlnmi_pkg::TLNMI_ENTRY;
			end
			tlnmi_pkg::TLNMI_ENTRY: begin
				next_entry_cnt = entry_cnt - 5'h1;
				if (entry_cnt == 5'h1) begin
					next_state = tlnmi_pkg::TLNMI_SERVICE;
				end
			end
			tlnmi_pkg::TLNMI_SERVICE: begin
				// Top service blocks everything until its return
				if (grant.top ? top_return : per_return) begin
					next_state = tlnmi_pkg::TLNMI_IDLE;
				end
			end
			default: next_state = tlnmi_pkg::TLNMI_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= tlnmi_pkg::TLNMI_IDLE;
			arb_cnt <= 3'h0;
			entry_cnt <= 5'h0;
			grant <= '0;
		end else begin
			state <= next_state;
			arb_cnt <= next_arb_cnt;
			entry_cnt <= next_entry_cnt;
			grant <= next_grant;
		end
	end
	// ==========================================================
	// Top control bits; no global enable or priority outputs are driven here
	logic next_src, next_edge, next_tmask, next_tpend, next_lock;
	always_comb begin
		next_src = top_source_select_wr ? top_source_select_in : top_source_select;
		next_edge = top_edge_select_wr ? top_edge_select_in : top_edge_select;
		next_tmask = top_mask_wr ? top_mask_in : top_mask_enable;
		// Set wins over acknowledge clear
		next_tpend = (top_pending_flag & ~top_ack) | top_event | top_pending_set;
		next_lock = top_unmaskable_lock | top_lock_set;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			top_source_select <= tlnmi_pkg::RST_SOURCE_SELECT;
			top_edge_select <= tlnmi_pkg::RST_EDGE_SELECT;
			top_mask_enable <= 1'b0;
			top_pending_flag <= 1'b0;
			top_unmaskable_lock <= 1'b0;
		end else begin
			top_source_select <= next_src;
			top_edge_select <= next_edge;
			top_mask_enable <= next_tmask;
			top_pending_flag <= next_tpend;
			top_unmaskable_lock <= next_lock;
		end
	end
	// ==========================================================
	// Peripheral channel bits, one slice per channel
	logic [CHANNELS-1:0] next_pend, next_mask;
	logic [3*CHANNELS-1:0] next_prio;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			wire logic ack_me = per_ack & (grant.chan == 3'(g));
			// Hardware and software set beat software or ack clear
			assign next_pend[g] = (pending_flag[g] & ~chan_pending_clr[g] & ~ack_me)
				| chan_event[g] | chan_pending_set[g];
			assign next_mask[g] = chan_mask_wr[g] ? chan_mask_in[g] : mask_flag[g];
			assign next_prio[3*g +: 3] = chan_prio_wr[g] ? chan_prio_in[3*g +: 3] : priority_field[3*g +: 3];
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (reset) begin
			pending_flag <= '0;
			mask_flag <= '0;
			priority_field <= {CHANNELS{tlnmi_pkg::RST_PRIORITY}};
		end else begin
			pending_flag <= next_pend;
			mask_flag <= next_mask;
			priority_field <= next_prio;
		end
	end
	// ==========================================================
	// Motor trip and wake unit
	logic next_mflag, next_hiz;
	logic [tlnmi_pkg::WAKE_LINES-1:0] next_wpend, next_wmask, wake_hw;
	always_comb begin
		wake_hw = '0;
		wake_hw[0] = motor_event;
		wake_hw[tlnmi_pkg::WAKE_PINS-1:1] = wk_s2;
		// Trip holds until software clears after line inactive
		next_mflag = motor_event | (motor_nmi_flag & ~motor_flag_clr);
		next_hiz = next_mflag;
		// All sixteen lines software accessible; pins set the low four
		next_wpend = (wake_pending & ~wake_pending_clr) | wake_hw | wake_pending_set;
		next_wmask = (wake_mask & ~wake_mask_wr) | (wake_mask_in & wake_mask_wr);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			motor_nmi_flag <= 1'b0;
			motor_phases_hiz <= 1'b0;
			wake_pending <= '0;
			wake_mask <= '0;
			wake_irq <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			motor_nmi_flag <= next_mflag;
			motor_phases_hiz <= next_hiz;
			wake_pending <= next_wpend;
			wake_mask <= next_wmask;
			wake_irq <= |(next_wpend & next_wmask);
			wake_request <= stop_mode & (|(wake_hw & next_wmask));
		end
	end
	// ==========================================================
	// Registered cpu-side strobes
	always_ff @(posedge clk) begin
		if (reset) begin
			abort_instr <= 1'b0;
			entry_start <= 1'b0;
			isr_start <= 1'b0;
			isr_top <= 1'b0;
			isr_chan <= 3'h0;
			in_top_service <= 1'b0;
		end else begin
			abort_instr <= (state == tlnmi_pkg::TLNMI_WAIT) & ~write_done;
			entry_start <= (state == tlnmi_pkg::TLNMI_ACK);
			isr_start <= (state == tlnmi_pkg::TLNMI_ENTRY) & (entry_cnt == 5'h1);
			isr_top <= next_grant.top;
			isr_chan <= next_grant.chan;
			in_top_service <= (next_state != tlnmi_pkg::TLNMI_IDLE) & next_grant.top;
		end
	end
endmodule : tlnmi_top

// *** tlnmi_pkg.sv ***
// Package for the top-level interrupt logic: states, reset values, cycle counts, carriers.
// Assumes a single 250 MHz clock and synchronous active-high reset.
package tlnmi_pkg;
	// ==========================================================
	// Reset values
	localparam logic RST_SOURCE_SELECT = 1'b1;
	localparam logic RST_EDGE_SELECT = 1'b0;
	localparam logic [2:0] RST_PRIORITY = 3'h7;
	localparam logic [2:0] PRIO_NEVER = 3'h7;
	// ==========================================================
	// Timing, in cpu clock cycles; then wake line and wake pin counts
	localparam int ARB_CYCLES = 5;
	localparam int ACK_EXTRA_CYCLES = 1;
	localparam int ENTRY_BASE_CYCLES = 18;
	localparam int ENTRY_STACK_CYCLES = 2;
	localparam int ENTRY_CSR_CYCLES = 2;
	localparam int ENTRY_WFI_CYCLES = 1;
	localparam int PER_RESP_MIN = 26;
	localparam int PER_RESP_MAX = 55;
	localparam int TOP_RESP_MIN = 22;
	localparam int TOP_RESP_MAX = 51;
	localparam logic [2:0] ARB_LAST = 3'(ARB_CYCLES - 1);
	localparam int WAKE_LINES = 16;
	localparam int WAKE_PINS = 4;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		TLNMI_IDLE = 3'b000,
		TLNMI_WAIT = 3'b001,
		TLNMI_ACK = 3'b010,
		TLNMI_ENTRY = 3'b011,
		TLNMI_SERVICE = 3'b100
	} tlnmi_state_t;
	// Entry options from the cpu
	typedef struct packed {
		logic stack_in_regfile;
		logic code_segment_push_enable;
		logic wait_for_irq;
	} tlnmi_entry_cfg_t;
	// Winner of an arbitration
	typedef struct packed {
		logic valid;
		logic top;
		logic [2:0] chan;
	} tlnmi_grant_t;
endpackage : tlnmi_pkg

// *** tlnmi_assertions.sv ***
// Concurrent checks on the ports of the top-level interrupt block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tlnmi_checker #(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic stop_mode,
	input wire logic global_irq_enable_in,
	input wire logic top_source_select,
	input wire logic top_pending_flag,
	input wire logic top_mask_enable,
	input wire logic top_unmaskable_lock,
	input wire logic [3*CHANNELS-1:0] priority_field,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_pending,
	input wire logic [tlnmi_pkg::WAKE_LINES-1:0] wake_mask,
	input wire logic wake_irq,
	input wire logic wake_request,
	input wire logic entry_start,
	input wire logic abort_instr,
	input wire logic isr_start,
	input wire logic isr_top,
	input wire logic [2:0] isr_chan,
	input wire logic in_top_service
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_reset_values: assert property ($fell(reset) |-> top_source_select && !top_pending_flag
		&& !top_unmaskable_lock && priority_field == {CHANNELS{tlnmi_pkg::RST_PRIORITY}}) else $error("Bad reset values");
	a_lock_sticky: assert property (top_unmaskable_lock |=> top_unmaskable_lock)
		else $error("Lock cleared");
	a_no_stop_grant: assert property ($rose(in_top_service) |-> !$past(stop_mode))
		else $error("Grant in stop mode");
	a_top_gate: assert property ($rose(in_top_service) |-> top_unmaskable_lock || (top_mask_enable
		&& global_irq_enable_in)) else $error("Top request not enabled");
	a_top_alone: assert property (in_top_service && $past(in_top_service) |-> isr_top)
		else $error("Other grant in top service");
	a_prio_seven: assert property (entry_start && !isr_top |->
		priority_field[3*isr_chan +: 3] != tlnmi_pkg::PRIO_NEVER) else $error("Priority seven acknowledged");
	a_entry_len: assert property (entry_start |-> ##[17:22] isr_start)
		else $error("Routine start late");
	a_abort_entry: assert property (abort_instr |=> entry_start)
		else $error("Abort without acknowledge");
	a_top_no_reentry: assert property (isr_start && isr_top |=> (!entry_start) [*8])
		else $error("Entry during top service");
	a_wake_irq: assert property ((|(wake_pending & wake_mask)) |-> ##[0:1] wake_irq)
		else $error("Wake irq missing");
	// Main scenarios
	c_top: cover property ($rose(in_top_service));
	c_chan: cover property (entry_start && !isr_top);
	c_wake: cover property ($rose(wake_request));
endmodule : tlnmi_checker

bind tlnmi_top tlnmi_checker #(.CHANNELS(CHANNELS)) i_chk (.clk, .reset, .stop_mode, .global_irq_enable_in,
	.top_source_select, .top_pending_flag, .top_mask_enable, .top_unmaskable_lock, .priority_field, .wake_pending,
	.wake_mask, .wake_irq, .wake_request, .entry_start, .abort_instr, .isr_start, .isr_top, .isr_chan,
	.in_top_service);

// *** tlnmi_cpu_model.sv ***
// Cpu core and watchdog model facing the top-level interrupt block.
// Assumes the block's clock; drives just after each rising edge.
`timescale 1ns/10ps
module tlnmi_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic wd_kick,
	input wire logic nmi_pin,
	input wire logic isr_start,
	input wire logic isr_top,
	output logic watchdog_eoc,
	output logic write_done,
	output logic instr_end,
	output logic top_return,
	output logic per_return,
	output logic motor_flag_clr
);
	logic [2:0] step;
	logic [2:0] run;
	logic busy;
	logic top;
	// ==========================================================
	// Seven-cycle instructions writing late, routines of eight cycles; reset quiets all outputs but watchdog_eoc
	always @(posedge clk) begin
		step <= (reset || step == 3'h6) ? 3'h0 : step + 3'h1;
		write_done <= step > 3'h3;
		instr_end <= step == 3'h6;
		watchdog_eoc <= wd_kick;
		top_return <= busy && top && run == 3'h7;
		per_return <= busy && !top && run == 3'h7;
		motor_flag_clr <= busy && top && !nmi_pin;
		run <= isr_start ? 3'h0 : run + 3'h1;
		busy <= !reset && (isr_start || (busy && run != 3'h7));
		top <= isr_start ? isr_top : top;
	end
endmodule : tlnmi_cpu_model

// *** tb.sv ***
// Self-checking testbench for the top-level interrupt block.
// Assumes the package, design, checker and cpu model are compiled first.
`timescale 1ns/10ps
module tb;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic reset, nmi_pin, top_pending_set, top_lock_set, global_irq_enable_in, stop_mode, wd_kick;
	logic top_source_select_wr, top_source_select_in, top_edge_select_wr, top_edge_select_in, top_mask_wr;
	logic top_mask_in, watchdog_eoc, write_done, instr_end, top_return, per_return, motor_flag_clr;
	logic [3:1] wake_pins;
	logic [7:0] chan_event, chan_pending_set, chan_pending_clr, chan_mask_wr, chan_mask_in, chan_prio_wr;
	logic [23:0] chan_prio_in;
	logic [2:0] current_priority_level;
	logic [15:0] wake_pending_set, wake_pending_clr, wake_mask_wr, wake_mask_in;
	tlnmi_pkg::tlnmi_entry_cfg_t entry_cfg;
	logic top_source_select, top_edge_select, top_pending_flag, top_mask_enable, top_unmaskable_lock;
	logic [7:0] pending_flag, mask_flag;
	logic [23:0] priority_field;
	logic [15:0] wake_pending, wake_mask;
	logic wake_irq, wake_request, motor_nmi_flag, motor_phases_hiz, abort_instr, entry_start, isr_start, isr_top;
	logic [2:0] isr_chan;
	logic in_top_service;
	int error_cnt = 0;
	int total_checks = 0;
	tlnmi_top #(.CHANNELS(8)) i_dut (.clk, .reset, .nmi_pin, .wake_pins, .watchdog_eoc, .top_source_select_wr,
		.top_source_select_in, .top_edge_select_wr, .top_edge_select_in, .top_mask_wr, .top_mask_in,
		.top_pending_set, .top_lock_set, .global_irq_enable_in, .chan_event, .chan_pending_set, .chan_pending_clr,
		.chan_mask_wr, .chan_mask_in, .chan_prio_in, .chan_prio_wr, .current_priority_level, .wake_pending_set,
		.wake_pending_clr, .wake_mask_wr, .wake_mask_in, .motor_flag_clr, .stop_mode, .write_done, .instr_end,
		.entry_cfg, .top_return, .per_return, .top_source_select, .top_edge_select, .top_pending_flag,
		.top_mask_enable, .top_unmaskable_lock, .pending_flag, .mask_flag, .priority_field, .wake_pending,
		.wake_mask, .wake_irq, .wake_request, .motor_nmi_flag, .motor_phases_hiz, .abort_instr, .entry_start,
		.isr_start, .isr_top, .isr_chan, .in_top_service);
	tlnmi_cpu_model i_cpu (.clk, .reset, .wd_kick, .nmi_pin, .isr_start, .isr_top, .watchdog_eoc, .write_done,
		.instr_end, .top_return, .per_return, .motor_flag_clr);
	// ==========================================================
	// Clock and tasks
	always #2 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// One-cycle write of source, edge and mask
	task automatic wr_top(input logic [2:0] w, input logic [2:0] d);
		{top_source_select_wr, top_edge_select_wr, top_mask_wr} = w;
		{top_source_select_in, top_edge_select_in, top_mask_in} = d;
		cyc(1);
		{top_source_select_wr, top_edge_select_wr, top_mask_wr} = 3'h0;
	endtask : wr_top
	// Bounded wait for a routine start, then its grant
	task automatic wait_isr(input logic top, input logic [2:0] ch);
		int n;
		n = 0;
		while (isr_start !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk(32'(n < 300), 32'h1);
		chk(32'(isr_top), 32'(top));
		if (!top) chk(32'(isr_chan), 32'(ch));
		cyc(1);
	endtask : wait_isr
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// Watchdog against a hang
	initial begin
		repeat (8000) @(negedge clk);
		error_cnt++;
		tally_and_finish();
	end
	// ==========================================================
	// Main sequence
	initial begin
		{nmi_pin, top_pending_set, top_lock_set, global_irq_enable_in, stop_mode, wd_kick, wake_pins} = '0;
		{top_source_select_wr, top_source_select_in, top_edge_select_wr, top_edge_select_in} = '0;
		{top_mask_wr, top_mask_in, chan_event, chan_pending_set, chan_pending_clr, chan_mask_wr} = '0;
		{chan_mask_in, chan_prio_wr, chan_prio_in, wake_pending_set, wake_pending_clr, wake_mask_wr} = '0;
		wake_mask_in = '0;
		current_priority_level = 3'h7;
		entry_cfg = '{1'b1, 1'b1, 1'b0};
		reset = 1'b1;
		cyc(12);
		reset = 1'b0;
		cyc(1);
		chk(32'({top_source_select, top_edge_select, top_pending_flag, top_unmaskable_lock}), 32'h8);
		chk(32'(priority_field), 32'hff_ffff);
		// Falling edge pends while masked, then served
		wr_top(3'h7, 3'h4);
		nmi_pin = 1'b1;
		cyc(6);
		chk(32'(top_pending_flag), 32'h0);
		nmi_pin = 1'b0;
		cyc(6);
		chk(32'(top_pending_flag), 32'h1);
		chk(32'({motor_nmi_flag, motor_phases_hiz}), 32'h3);
		global_irq_enable_in = 1'b1;
		cyc(20);
		chk(32'(in_top_service), 32'h0);
		global_irq_enable_in = 1'b0;
		wr_top(3'h1, 3'h1);
		cyc(20);
		chk(32'(top_mask_enable), 32'h1);
		chk(32'(in_top_service), 32'h0);
		global_irq_enable_in = 1'b1;
		wait_isr(1'b1, 3'h0);
		chk(32'(top_pending_flag), 32'h0);
		cyc(12);
		chk(32'({motor_nmi_flag, motor_phases_hiz}), 32'h0);
		// Watchdog source ignores the pin; lock bypasses enable
		wr_top(3'h7, 3'h2);
		global_irq_enable_in = 1'b0;
		nmi_pin = 1'b1;
		cyc(6);
		nmi_pin = 1'b0;
		cyc(6);
		chk(32'(top_pending_flag), 32'h0);
		wd_kick = 1'b1;
		cyc(2);
		wd_kick = 1'b0;
		cyc(6);
		chk(32'(top_pending_flag), 32'h1);
		top_lock_set = 1'b1;
		cyc(1);
		top_lock_set = 1'b0;
		wait_isr(1'b1, 3'h0);
		chk(32'(top_unmaskable_lock), 32'h1);
		cyc(12);
		wr_top(3'h4, 3'h4);
		nmi_pin = 1'b1;
		wait_isr(1'b1, 3'h0);
		nmi_pin = 1'b0;
		cyc(12);
		// Stop mode holds a software request; wake line wakes
		{wake_mask_wr, wake_mask_in} = {16'h0002, 16'h0002};
		stop_mode = 1'b1;
		top_pending_set = 1'b1;
		cyc(1);
		{top_pending_set, wake_mask_wr} = '0;
		cyc(30);
		chk(32'(in_top_service), 32'h0);
		wake_pins = 3'h1;
		cyc(5);
		chk(32'({wake_request, wake_pending[1]}), 32'h3);
		stop_mode = 1'b0;
		wait_isr(1'b1, 3'h0);
		wake_pins = 3'h0;
		cyc(12);
		// Channels: order, mask, priority seven, software pending
		global_irq_enable_in = 1'b1;
		{chan_prio_wr, chan_prio_in, chan_mask_wr, chan_mask_in} = {8'h64, 24'he0_feff, 8'h65, 8'h25};
		cyc(1);
		{chan_prio_wr, chan_mask_wr} = '0;
		chk(32'(mask_flag), 32'h25);
		current_priority_level = 3'h1;
		chan_event = 8'h65;
		cyc(1);
		chan_event = 8'h00;
		cyc(20);
		chk(32'(pending_flag), 32'h65);
		current_priority_level = 3'h7;
		wait_isr(1'b0, 3'h5);
		wait_isr(1'b0, 3'h2);
		cyc(40);
		chk(32'(pending_flag), 32'h41);
		{chan_pending_set, chan_pending_clr} = {8'h08, 8'h40};
		cyc(1);
		{chan_pending_set, chan_pending_clr} = '0;
		cyc(20);
		chk(32'(pending_flag), 32'h09);
		// Unused wake line as a software interrupt
		{wake_pending_clr, wake_pending_set, wake_mask_wr, wake_mask_in} = {16'h0003, {3{16'h0200}}};
		cyc(1);
		{wake_pending_clr, wake_pending_set, wake_mask_wr} = '0;
		cyc(3);
		chk(32'(wake_irq), 32'h1);
		chk(32'({wake_pending, wake_mask}), 32'h0200_0202);
		wake_pending_clr = 16'h0200;
		cyc(1);
		wake_pending_clr = '0;
		cyc(3);
		chk(32'(wake_irq), 32'h0);
		tally_and_finish();
	end
endmodule : tb
